// file: rtl/btc_defines.svh
// constants for the branch target cache control block
// assumes inclusion by bare name from the package and the design module
`ifndef BTC_DEFINES_SVH
`define BTC_DEFINES_SVH

// **********************************************
// register byte offsets on the apb slave
// **********************************************
`define OFS_CONTROL 12'h000
`define OFS_TUNING 12'h004
`define OFS_LOCK 12'h008

// **********************************************
// widths
// **********************************************
`define ADDR_W 12
`define DATA_W 32
`define FADDR_W 17
`define SLOT_W 6

// **********************************************
// control register fields
// **********************************************
`define CTL_WRITE_EN 7
`define CTL_READ_EN 6
`define CTL_PREFETCH_EN 5
`define CTL_RETURN_DEST 3
`define CTL_ISR_CODE 2
`define CTL_TABLE_READ 1
`define CTL_RESET 8'hE6

// **********************************************
// tuning and lock register fields
// **********************************************
`define TUN_FIXED_SLOT 2
`define TUN_RESET 8'h00
`define LCK_PUSH_EN 7
`define LCK_POP 6
`define LCK_SLOT_HI 5
`define LCK_SLOT_LO 0

// **********************************************
// slot pointer limits and segment address mask
// **********************************************
`define SLOT_TOP 6'h3F
`define SLOT_LAST_PUSH 6'h03
`define SLOT_ZERO 6'h00
`define SLOT_ONE 6'h01
`define SEG_MASK 17'h1FFFC

`endif

// file: rtl/btc_pkg.sv
// types shared by the branch target cache control block
// assumes btc_defines.svh is on the include path
`include "btc_defines.svh"

package btc_pkg;

    // fill request from the fetch engine, one cycle wide
    typedef struct packed {
        logic valid;                      // request present this cycle
        logic [`FADDR_W-1:0] addr;        // flash byte address
        logic [`SLOT_W-1:0] victim;       // slot chosen by replacement
        logic return_dest;                // target of interrupt return
        logic isr_code;                   // fetched inside a service routine
        logic table_read;                 // data of a table read
    } fill_req_t;

    // write command towards the cache array
    typedef struct packed {
        logic we;                         // write one segment
        logic push;                       // write is a locking push
        logic [`SLOT_W-1:0] slot;         // target slot
        logic [`FADDR_W-1:0] seg_addr;    // segment aligned address
    } cache_wr_t;

    // flash program or erase notice
    typedef struct packed {
        logic valid;                      // flash write or erase done
        logic [`FADDR_W-1:0] addr;        // first affected byte
        logic [`FADDR_W-1:0] len;         // affected byte count
    } flash_evt_t;

endpackage : btc_pkg

// file: rtl/branch_target_cache_control.sv
// control logic of a branch target cache: apb registers, fill gating,
// slot locking by push and pop, flash invalidation and read modes.
// assumes an apb master on pclk and fetch side logic on the same clock.
// assumes the cache array applies cache_wr and invalidate as they appear,
// and that the fetch side picks the replacement victim itself.
//
// Operation
// [RULE1] return destinations cached only when enabled
// [RULE2] service routine code cached unless disabled
// [RULE3] table read data not cached when disabled
// [RULE4] fixed slot sends table data to slot 0
// [RULE5] write disable stops fills, pushes still write
// [RULE6] flash write or erase always invalidates
// [RULE7] read disable stops cache supply, fills continue
// [RULE8] prefetch bit clear disables prefetch engine
// [RULE9] no reads and no prefetch gives fixed rate
// [RULE10] at most 61 slots locked together
// [RULE11] push writes segment into pointed slot
// [RULE12] pointer decrements after each push
// [RULE13] slots above pointer never refilled normally
// [RULE14] pop increments pointer, contents stay
// [RULE15] software keeps slots 1 and 0 unlocked
// [RULE16] six bit pointer covers 64 slots
`timescale 1ns/100ps
`default_nettype none
`include "btc_defines.svh"

module branch_target_cache_control (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`ADDR_W-1:0] paddr,
    input wire logic [`DATA_W-1:0] pwdata,
    output logic [`DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire btc_pkg::fill_req_t fill_req,
    input wire btc_pkg::flash_evt_t flash_evt,
    output btc_pkg::cache_wr_t cache_wr,
    output btc_pkg::flash_evt_t invalidate,
    output logic cache_read_en,
    output logic prefetch_en,
    output logic fixed_rate
);

    // **********************************************
    // register state
    // **********************************************
    // byte wide registers; the pop strobe is never stored, so it reads as
    // zero without any extra masking on the read path
    logic [7:0] cache_control_reg;        // enables
    logic [7:0] cache_tuning_reg;         // fixed slot option
    logic lock_push_en;                   // push mode
    logic [`SLOT_W-1:0] lock_slot_pointer; // next lockable slot

    // **********************************************
    // apb decode
    // **********************************************
    // whole address compare; any other offset, aligned or not, is unmapped
    wire sel_ctl = (paddr == `OFS_CONTROL);
    wire sel_tun = (paddr == `OFS_TUNING);
    wire sel_lck = (paddr == `OFS_LOCK);
    wire mapped = sel_ctl | sel_tun | sel_lck;

    // writes land only on the access edge, the one edge with penable high
    wire acc = psel & penable;
    wire wr_ok = acc & pwrite & mapped;
    wire wr_ctl = wr_ok & sel_ctl;
    wire wr_tun = wr_ok & sel_tun;
    wire wr_lck = wr_ok & sel_lck;
    // pop is a strobe riding on a lock write
    wire pop_req = wr_lck & pwdata[`LCK_POP];

    // slave never stalls; unmapped access answers with an error
    // zero wait states: a register write is seen by the fill logic next cycle
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // lock register read view, pop bit always reads zero
    // upper 24 bits of every read are zero
    wire [7:0] lock_view = {lock_push_en, 1'b0, lock_slot_pointer};
    wire [7:0] rd_mux = sel_ctl ? cache_control_reg :
                        sel_tun ? cache_tuning_reg :
                        sel_lck ? lock_view : 8'h00;

    // **********************************************
    // enable bits
    // **********************************************
    // class bits gate normal fills only; a push ignores all of them
    wire write_en = cache_control_reg[`CTL_WRITE_EN];
    wire return_dest_cache_en = cache_control_reg[`CTL_RETURN_DEST];
    wire isr_code_cache_en = cache_control_reg[`CTL_ISR_CODE];
    wire table_read_cache_en = cache_control_reg[`CTL_TABLE_READ];
    wire table_read_fixed_slot = cache_tuning_reg[`TUN_FIXED_SLOT];
    // read and prefetch bits leave through the registered outputs below

    // **********************************************
    // fill gating
    // **********************************************
    // pointer of zero means slot 1 was locked: whole cache unlocked
    wire lock_active = (lock_slot_pointer != `SLOT_ZERO); // [RULE15]
    // push refused once 61 slots are held, keeping slots 2..0 free
    // a refused push writes nothing and leaves the pointer alone
    wire push_room = (lock_slot_pointer >= `SLOT_LAST_PUSH); // [RULE10]

    // a push needs a valid table read while push mode is on
    wire push_hit = fill_req.valid & fill_req.table_read & lock_push_en;
    wire push_go = push_hit & push_room; // [RULE11]
    // exclusion classes
    // the three classes are independent; any one of them refuses the fill
    wire excl_reti = fill_req.return_dest & ~return_dest_cache_en; // [RULE1]
    wire excl_isr = fill_req.isr_code & ~isr_code_cache_en; // [RULE2]
    wire excl_tbl = fill_req.table_read & ~table_read_cache_en; // [RULE3]
    // table data may be pinned to slot 0
    // a pinned fill is still checked against locks; slot 0 is never locked
    wire pin_zero = fill_req.table_read & table_read_fixed_slot; // [RULE4]
    wire [`SLOT_W-1:0] norm_slot = pin_zero ? `SLOT_ZERO : fill_req.victim;
    // full 6 bit compare: 64 slots, higher ones locked
    wire slot_locked = lock_active & (norm_slot > lock_slot_pointer); // [RULE13] [RULE16]

    // a normal fill needs writes on, no excluded class, a free slot and no push;
    // limitation: a locked victim is dropped, not re-picked, so that fill is lost
    wire norm_go = fill_req.valid & write_en & ~excl_reti & ~excl_isr
                   & ~excl_tbl & ~slot_locked & ~push_hit; // [RULE5]
    // segment holding the addressed byte
    // four byte segments, so the two low address bits are cleared
    wire [`FADDR_W-1:0] seg = fill_req.addr & `SEG_MASK;

    // **********************************************
    // pointer update
    // **********************************************
    // pop, write and push share one pointer; one source wins each cycle
    wire ptr_at_top = (lock_slot_pointer == `SLOT_TOP);
    logic [`SLOT_W-1:0] next_ptr;
    // pop beats a plain lock write, which beats push in one cycle
    always_comb begin
        next_ptr = lock_slot_pointer;
        if (pop_req) begin
            // pop at the top is ignored rather than wrapping to zero
            if (!ptr_at_top) begin
                next_ptr = lock_slot_pointer + `SLOT_ONE; // [RULE14]
            end
        end else if (wr_lck) begin
            // plain lock write loads the pointer field
            next_ptr = pwdata[`LCK_SLOT_HI:`LCK_SLOT_LO];
        end else if (push_go) begin
            // the pointed slot is now taken, move to the next lockable one
            next_ptr = lock_slot_pointer - `SLOT_ONE; // [RULE12]
        end
    end

    // **********************************************
    // registers
    // **********************************************
    // control and tuning writes
    // bits above the low byte are dropped, the registers are one byte wide
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cache_control_reg <= `CTL_RESET;
            cache_tuning_reg <= `TUN_RESET;
        end else begin
            if (wr_ctl) begin
                cache_control_reg <= pwdata[7:0];
            end
            if (wr_tun) begin
                cache_tuning_reg <= pwdata[7:0];
            end
        end
    end

    // lock register
    // a push in the cycle of a lock write still writes the array, but the
    // pointer follows the software write; software avoids that overlap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_push_en <= 1'b0;
            lock_slot_pointer <= `SLOT_TOP;
        end else begin
            if (wr_lck) begin
                lock_push_en <= pwdata[`LCK_PUSH_EN];
            end
            lock_slot_pointer <= next_ptr;
        end
    end

    // read data captured in setup, stable through access
    // so the value cannot move under the master's sampling edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= {24'h000000, rd_mux};
        end
    end

    // cache write command, one cycle after the request
    // slot and address follow the input every cycle; only we qualifies them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cache_wr <= '0;
        end else begin
            cache_wr.we <= push_go | norm_go;
            cache_wr.push <= push_go;
            cache_wr.slot <= push_go ? lock_slot_pointer : norm_slot; // [RULE11]
            cache_wr.seg_addr <= seg;
        end
    end

    // flash changes invalidate regardless of any enable
    // the length passes through; the array decides which lines it covers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            invalidate <= '0;
        end else begin
            invalidate <= flash_evt; // [RULE6]
        end
    end

    // read mode outputs
    // one cycle behind a control write, which the fetch side tolerates;
    // fixed rate means every instruction waits for flash to deliver it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cache_read_en <= 1'b1;
            prefetch_en <= 1'b1;
            fixed_rate <= 1'b0;
        end else begin
            cache_read_en <= cache_control_reg[`CTL_READ_EN]; // [RULE7]
            prefetch_en <= cache_control_reg[`CTL_PREFETCH_EN]; // [RULE8]
            fixed_rate <= ~cache_control_reg[`CTL_READ_EN]
                          & ~cache_control_reg[`CTL_PREFETCH_EN]; // [RULE9]
        end
    end

    // **********************************************
    // assertions
    // **********************************************
    // all checks share pclk and are off while reset is held
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // excluded classes: a refused fill leaves we low on the next cycle

    AST_RETI_EXCL: assert property (fill_req.valid && fill_req.return_dest && !return_dest_cache_en // [RULE1]
        && !push_hit |=> !cache_wr.we) else $error("return destination cached");
    AST_ISR_EXCL: assert property (fill_req.valid && fill_req.isr_code && !isr_code_cache_en // [RULE2]
        && !push_hit |=> !cache_wr.we) else $error("isr code cached");
    AST_TBL_EXCL: assert property (fill_req.valid && fill_req.table_read && !table_read_cache_en // [RULE3]
        && !push_hit |=> !cache_wr.we) else $error("table data cached");
    // slot choice, write gating, invalidation and fixed rate
    AST_FIXED_SLOT: assert property (cache_wr.we && !cache_wr.push && $past(fill_req.table_read) // [RULE4]
        && $past(table_read_fixed_slot) |-> cache_wr.slot == `SLOT_ZERO)
        else $error("table data off slot 0");
    AST_WR_DISABLE: assert property (!write_en |=> !cache_wr.we || cache_wr.push) // [RULE5]
        else $error("fill while writes disabled");
    AST_INVALIDATE: assert property (flash_evt.valid |=> invalidate.valid // [RULE6]
        && invalidate.addr == $past(flash_evt.addr)) else $error("flash change not invalidated");
    AST_FIXED_RATE: assert property (wr_ctl && !pwdata[`CTL_READ_EN] && !pwdata[`CTL_PREFETCH_EN] // [RULE9]
        |-> ##2 fixed_rate && !cache_read_en && !prefetch_en) else $error("fixed rate not entered");
    // slot locking: pointer movement, locked slots, push slot and segment
    AST_MAX_LOCK: assert property (push_hit && lock_slot_pointer < `SLOT_LAST_PUSH // [RULE10]
        && !wr_lck |=> !cache_wr.we && $stable(lock_slot_pointer)) else $error("too many locked");
    AST_PUSH: assert property (push_go && !wr_lck |=> cache_wr.we && cache_wr.push // [RULE11]
        && cache_wr.slot == $past(lock_slot_pointer)
        && lock_slot_pointer == $past(lock_slot_pointer) - `SLOT_ONE) // [RULE12]
        else $error("push slot or pointer wrong");
    AST_LOCKED: assert property (cache_wr.we && !cache_wr.push && $past(lock_active) // [RULE13]
        |-> cache_wr.slot <= $past(lock_slot_pointer)) else $error("locked slot replaced");
    AST_POP: assert property (pop_req && !ptr_at_top // [RULE14]
        |=> lock_slot_pointer == $past(lock_slot_pointer) + `SLOT_ONE) else $error("pop failed");
    AST_POP_TOP: assert property (pop_req && ptr_at_top // [RULE14]
        |=> lock_slot_pointer == `SLOT_TOP) else $error("pop wrapped past the top");
    AST_PUSH_SEG: assert property (push_go // [RULE11]
        |=> cache_wr.seg_addr == ($past(fill_req.addr) & `SEG_MASK))
        else $error("push segment wrong");
    AST_PUSH_NO_WREN: assert property (push_go && !write_en // [RULE5]
        |=> cache_wr.we && cache_wr.push) else $error("push lost while writes disabled");

    // pointer at zero unlocks the whole cache
    AST_ALL_UNLOCKED: assert property (fill_req.valid && write_en && !push_hit // [RULE15]
        && !excl_reti && !excl_isr && !excl_tbl && lock_slot_pointer == `SLOT_ZERO
        |=> cache_wr.we) else $error("fill refused with nothing locked");

    // mode outputs follow a control write two edges later
    AST_READ_EN: assert property (wr_ctl // [RULE7]
        |-> ##2 cache_read_en == $past(pwdata[`CTL_READ_EN], 2))
        else $error("read enable not applied");
    AST_PREFETCH_EN: assert property (wr_ctl // [RULE8]
        |-> ##2 prefetch_en == $past(pwdata[`CTL_PREFETCH_EN], 2))
        else $error("prefetch enable not applied");

    // coverage of the main scenarios
    COV_PUSH: cover property (push_go ##1 cache_wr.push);
    COV_POP: cover property (pop_req && !ptr_at_top);
    COV_FIXED: cover property (fixed_rate);
    COV_LOCK_BLOCK: cover property (fill_req.valid && slot_locked && write_en);
    COV_ALL_UNLOCKED: cover property (fill_req.valid && lock_slot_pointer == `SLOT_ZERO);

endmodule // branch_target_cache_control

`default_nettype wire

// file: test/fetch_model.sv
// fetch side model: offers fill requests and flash notices to the block
// assumes the bench calls issue() and samples results after it returns
`timescale 1ns/100ps
`default_nettype none

module fetch_model (
    input wire logic pclk,
    output var btc_pkg::fill_req_t fill_req,
    output var btc_pkg::flash_evt_t flash_evt
);
    // quiet at time zero, no request pending
    initial begin
        fill_req = '0;
        flash_evt = '0;
    end

    // one-cycle request; returns just after the edge that registers the answer
    task automatic issue(input btc_pkg::fill_req_t r, input btc_pkg::flash_evt_t e);
        btc_pkg::fill_req_t x;
        btc_pkg::flash_evt_t y;
        @(posedge pclk);
        fill_req <= r;
        flash_evt <= e;
        @(posedge pclk);
        // released fields show garbage, never the stale value
        x = ~r;
        x.valid = 1'b0;
        y = ~e;
        y.valid = 1'b0;
        fill_req <= x;
        flash_evt <= y;
    endtask
endmodule // fetch_model

`default_nettype wire

// file: test/tb_top.sv
// self-checking bench: apb master, fetch model and an integer reference model
// assumes the design, its package and test/fetch_model.sv are compiled first
`timescale 1ns/100ps
`default_nettype none
`include "btc_defines.svh"

module tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, cre, pfe, fxr;
    logic [`ADDR_W-1:0] paddr;
    logic [`DATA_W-1:0] pwdata, prdata, rd;
    btc_pkg::fill_req_t fill_req, rq;
    btc_pkg::flash_evt_t flash_evt, invalidate, ev;
    btc_pkg::cache_wr_t cache_wr;
    int fails, checked, cyc, ctl, tun, ptr, pen, i, k; // reference state as integers

    branch_target_cache_control dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .fill_req(fill_req),
        .flash_evt(flash_evt), .cache_wr(cache_wr), .invalidate(invalidate),
        .cache_read_en(cre), .prefetch_en(pfe), .fixed_rate(fxr));
    fetch_model fm_u (.pclk(pclk), .fill_req(fill_req), .flash_evt(flash_evt));

    // 200 MHz clock
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // hang guard, well above the expected run
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            summarize();
        end
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one apb transfer; waits for pready, takes data at that edge only
    task automatic apb(input logic wr, input logic [`ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // ends once pready is high; only the bench timeout ends a stalled wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // write and mirror into the reference model; pop outranks the pointer field
    task automatic wreg(input logic [`ADDR_W-1:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
        if (a == `OFS_CONTROL) ctl = d;
        else if (a == `OFS_TUNING) tun = d;
        else if (a == `OFS_LOCK) pen = d[7];
        if (a == `OFS_LOCK && d[6] && ptr != 63) ptr++;
        else if (a == `OFS_LOCK && !d[6]) ptr = d[5:0];
    endtask

    // read and compare against the reference model; unmapped reads zero
    task automatic rreg(input logic [`ADDR_W-1:0] a);
        int exp;
        exp = (a == `OFS_CONTROL) ? ctl : (a == `OFS_TUNING) ? tun : 0;
        if (a == `OFS_LOCK) exp = pen * 128 + ptr;
        apb(1'b0, a, 32'h0);
        chk("prdata", rd, exp);
        chk("pslverr", err, a > `OFS_LOCK);
    endtask

    // one fill through the fetch model, predicted from the reference state
    task automatic fill(input btc_pkg::fill_req_t r, input btc_pkg::flash_evt_t e);
        int s, w, p;
        p = pen && r.table_read;
        s = p ? ptr : (r.table_read && tun[2] && ctl[1]) ? 0 : r.victim;
        w = ctl[7] && !(r.return_dest && !ctl[3]) && !(r.isr_code && !ctl[2]);
        w = w && !(r.table_read && !ctl[1]) && !(ptr != 0 && s > ptr);
        if (p) w = ptr >= 3;
        w = w && r.valid;
        fm_u.issue(r, e);
        #1;
        chk("we", cache_wr.we, w);
        if (w) chk("slot", cache_wr.slot, s);
        if (w) chk("push", cache_wr.push, p);
        if (w) chk("seg", cache_wr.seg_addr, r.addr & `SEG_MASK);
        chk("invalidate", invalidate, e);
        chk("read_en", cre, ctl[6]);
        chk("prefetch_en", pfe, ctl[5]);
        chk("fixed_rate", fxr, !ctl[6] && !ctl[5]);
        if (w && p) ptr--;
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        ctl = 'hE6;
        tun = 0;
        ptr = 63;
        pen = 0;
        void'($urandom(50106));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        // reset values and the unmapped word
        for (k = 0; k < 4; k++) rreg(k * 4);
        $display("test reset values done");
        // push until the lock limit, one more is refused, then pop twice
        wreg(`OFS_LOCK, 8'hBF);
        for (k = 0; k < 62; k++) begin
            rq = btc_pkg::fill_req_t'($urandom);
            rq.valid = 1'b1;
            rq.table_read = 1'b1;
            fill(rq, '0);
        end
        rreg(`OFS_LOCK);
        wreg(`OFS_LOCK, 8'hC0);
        wreg(`OFS_LOCK, 8'h40);
        rreg(`OFS_LOCK);
        $display("test push and pop done");
        // pointer at zero: every slot is free again for normal fills
        wreg(`OFS_LOCK, 8'h00);
        rq = btc_pkg::fill_req_t'($urandom);
        rq.valid = 1'b1;
        rq.victim = `SLOT_TOP;
        rq.return_dest = 1'b0;
        rq.table_read = 1'b0;
        fill(rq, '0);
        $display("test pointer zero done");
        // random mix of settings and traffic; pointer field writes use 3 or above
        for (i = 0; i < 400; i++) begin
            k = $urandom_range(0, 5);
            if (k == 0) wreg(`OFS_CONTROL, 8'($urandom) & 8'hEE);
            else if (k == 1) wreg(`OFS_TUNING, 8'($urandom) & 8'h04);
            else if (k == 2) wreg(`OFS_LOCK, {1'($urandom), 1'b0, 6'(3 + $urandom_range(0, 60))});
            else if (k == 3) wreg(`OFS_LOCK, 8'h40);
            rq = btc_pkg::fill_req_t'($urandom);
            ev = btc_pkg::flash_evt_t'({$urandom, $urandom});
            fill(rq, ev);
            rreg(4 * $urandom_range(0, 3));
        end
        $display("test random traffic done");
        summarize();
    end
endmodule // tb_top

`default_nettype wire
